// ==== sdtr_target.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdtr_target #(
  parameter int ID_W = 4,
  parameter int MAX_RETRY = 3
) (
  // Link to the initiator.
  sdtr_link_if.target_end link,
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Connection control.
  input wire logic [ID_W-1:0] peer_id,
  input wire logic connect,
  input wire logic start_neg,
  input wire logic ecs_set,
  input wire logic corrupt,
  input wire logic data_phase,
  input wire logic [7:0] min_period,
  input wire logic [7:0] max_offset,
  // Agreement with the connected peer.
  output logic [7:0] cur_period,
  output logic [7:0] cur_offset,
  output logic [7:0] pace_cycles,
  output logic sync_en,
  output logic ecs_active,
  output logic bus_free_pulse
);
  import sdtr_pkg::*;

  localparam int NPEER = 1 << ID_W;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_MOUT = 6'b000010,
    ST_MIN = 6'b000100,
    ST_ACK = 6'b001000,
    ST_CHK = 6'b010000,
    ST_FREE = 6'b100000
  } state_t;

  function automatic phase_t phase_of(input state_t s);
    case (s)
      ST_MOUT: return PH_MSG_OUT;
      // Message in holds while the target looks for attention, so no false phase change shows.
      ST_MIN, ST_ACK, ST_CHK: return PH_MSG_IN;
      ST_FREE: return PH_BUS_FREE;
      default: return PH_OTHER;
    endcase
  endfunction : phase_of

  state_t state_reg, state_next;
  logic [39:0] msg_reg, msg_next;
  logic [2:0] len_reg, len_next;
  logic [2:0] idx_reg, idx_next;
  logic [2:0] rx_idx_reg, rx_idx_next;
  logic [23:0] rx_buf_reg, rx_buf_next;
  logic orig_reg, orig_next;
  logic replied_reg, replied_next;
  logic pend_ok_reg, pend_ok_next;
  logic [7:0] pend_per_reg, pend_per_next;
  logic [7:0] pend_off_reg, pend_off_next;
  logic [2:0] retry_reg, retry_next;
  logic ecs_reg, ecs_next;
  logic [ID_W-1:0] peer_reg;
  logic [7:0] rec_per_reg [NPEER];
  logic [7:0] rec_off_reg [NPEER];
  logic need_reg [NPEER];
  logic rec_wr;
  logic rec_need;
  logic [7:0] rec_per;
  logic [7:0] rec_off;
  logic [7:0] t_data_reg, t_data_next;
  logic t_par_reg;
  logic t_valid_reg, t_valid_next;
  phase_t phase_reg;
  logic free_next;

  wire par_good = link.i_par == par_of(link.i_data);
  wire [7:0] rx_len = rx_buf_reg[23:16];
  wire [7:0] rx_code = rx_buf_reg[15:8];
  wire [7:0] rx_per = rx_buf_reg[7:0];
  wire is_sdtr = rx_len == SDTR_EXT_LEN && rx_code == SDTR_CODE;
  wire [7:0] fit_per = (rx_per < min_period) ? min_period : rx_per;
  wire [7:0] fit_off = (link.i_data > max_offset) ? max_offset : link.i_data;
  wire answer_bad = rx_per < min_period || link.i_data > max_offset;
  wire retry_out = retry_reg == 3'(MAX_RETRY);
  wire [7:0] tx_byte = msg_reg[39 - 8 * idx_reg -: 8];

  always_comb begin
    state_next = state_reg;
    msg_next = msg_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    rx_idx_next = rx_idx_reg;
    rx_buf_next = rx_buf_reg;
    orig_next = orig_reg;
    replied_next = replied_reg;
    pend_ok_next = pend_ok_reg;
    pend_per_next = pend_per_reg;
    pend_off_next = pend_off_reg;
    retry_next = retry_reg;
    ecs_next = ecs_reg | ecs_set;
    rec_wr = 1'b0;
    rec_need = 1'b0;
    rec_per = pend_per_reg;
    rec_off = pend_off_reg;
    t_valid_next = 1'b0;
    t_data_next = t_data_reg;
    free_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        retry_next = '0;
        rx_idx_next = '0;
        if (link.atn) begin
          state_next = ST_MOUT;
        end else if (start_neg || (connect && need_reg[peer_id])) begin
          msg_next = sdtr_msg(min_period, max_offset);
          len_next = SDTR_BYTES;
          idx_next = '0;
          orig_next = 1'b1;
          state_next = ST_MIN;
        end
      end
      ST_MIN: begin
        t_valid_next = 1'b1;
        t_data_next = tx_byte;
        idx_next = idx_reg + 3'h1;
        if (idx_reg == len_reg - 3'h1) begin
          state_next = ST_ACK;
        end
      end
      ST_ACK: begin
        state_next = ST_CHK;
      end
      ST_CHK: begin
        if (link.atn) begin
          state_next = ST_MOUT;
        end else begin
          if (orig_reg || replied_reg) begin
            rec_wr = 1'b1;
            rec_per = orig_reg ? 8'h00 : pend_per_reg;
            rec_off = orig_reg ? OFFSET_ASYNC : pend_off_reg;
          end
          orig_next = 1'b0;
          replied_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_MOUT: begin
        if (link.i_valid && !par_good) begin
          rx_idx_next = '0;
          if (retry_out) begin
            state_next = ST_FREE;
            rec_wr = 1'b1;
            rec_per = 8'h00;
            rec_off = OFFSET_ASYNC;
          end else begin
            retry_next = retry_reg + 3'h1;
          end
        end else if (link.i_valid && rx_idx_reg == 3'h0) begin
          replied_next = 1'b0;
          if (replied_reg && link.i_data != MSG_PAR_ERR && link.i_data != MSG_REJECT) begin
            rec_wr = 1'b1;
          end
          case (link.i_data)
            MSG_REL_RECOV: begin
              // A new set in the same cycle wins over the release.
              ecs_next = ecs_set;
              state_next = ST_FREE;
            end
            MSG_PAR_ERR: begin
              if (replied_reg) begin
                rec_wr = 1'b1;
                rec_per = 8'h00;
                rec_off = OFFSET_ASYNC;
              end
              if (retry_out) begin
                state_next = ST_FREE;
                rec_wr = 1'b1;
                rec_per = 8'h00;
                rec_off = OFFSET_ASYNC;
              end else begin
                retry_next = retry_reg + 3'h1;
                replied_next = replied_reg;
                idx_next = '0;
                state_next = ST_MIN;
              end
            end
            MSG_REJECT: begin
              if (replied_reg || orig_reg) begin
                rec_wr = 1'b1;
                rec_per = 8'h00;
                rec_off = OFFSET_ASYNC;
                orig_next = 1'b0;
                pend_ok_next = 1'b0;
              end
            end
            MSG_DEV_RESET: begin
              rec_wr = 1'b1;
              rec_need = 1'b1;
              rec_per = 8'h00;
              rec_off = OFFSET_ASYNC;
              state_next = ST_FREE;
            end
            MSG_EXT: begin
              rx_idx_next = 3'h1;
            end
            default: begin
            end
          endcase
        end else if (link.i_valid) begin
          rx_buf_next = {rx_buf_reg[15:0], link.i_data};
          rx_idx_next = rx_idx_reg + 3'h1;
          if (rx_idx_reg == RX_LAST) begin
            rx_idx_next = '0;
            if (is_sdtr && orig_reg && answer_bad) begin
              msg_next = {MSG_REJECT, 32'h0};
              len_next = ONE_BYTE;
              idx_next = '0;
              orig_next = 1'b0;
              pend_ok_next = 1'b0;
              rec_wr = 1'b1;
              rec_per = 8'h00;
              rec_off = OFFSET_ASYNC;
              state_next = ST_MIN;
            end else if (is_sdtr && orig_reg) begin
              pend_per_next = rx_per;
              pend_off_next = link.i_data;
              pend_ok_next = 1'b1;
            end else if (is_sdtr) begin
              pend_per_next = fit_per;
              pend_off_next = fit_off;
              msg_next = sdtr_msg(fit_per, fit_off);
              len_next = SDTR_BYTES;
              idx_next = '0;
              replied_next = 1'b1;
              state_next = ST_MIN;
            end
          end
        end else if (!link.atn) begin
          if (pend_ok_reg && orig_reg) begin
            rec_wr = 1'b1;
          end
          orig_next = 1'b0;
          pend_ok_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_FREE: begin
        free_next = 1'b1;
        orig_next = 1'b0;
        replied_next = 1'b0;
        pend_ok_next = 1'b0;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      msg_reg <= '0;
      len_reg <= '0;
      idx_reg <= '0;
      rx_idx_reg <= '0;
      rx_buf_reg <= '0;
      orig_reg <= 1'b0;
      replied_reg <= 1'b0;
      pend_ok_reg <= 1'b0;
      pend_per_reg <= '0;
      pend_off_reg <= '0;
      retry_reg <= '0;
      ecs_reg <= 1'b0;
      peer_reg <= '0;
    end else begin
      state_reg <= state_next;
      msg_reg <= msg_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      rx_idx_reg <= rx_idx_next;
      rx_buf_reg <= rx_buf_next;
      orig_reg <= orig_next;
      replied_reg <= replied_next;
      pend_ok_reg <= pend_ok_next;
      pend_per_reg <= pend_per_next;
      pend_off_reg <= pend_off_next;
      retry_reg <= retry_next;
      ecs_reg <= ecs_next;
      if (state_reg == ST_IDLE) begin
        peer_reg <= peer_id;
      end
    end
  end

  // One agreement record per peer, asynchronous after reset.
  for (genvar g = 0; g < NPEER; g++) begin : g_rec
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        rec_per_reg[g] <= '0;
        rec_off_reg[g] <= OFFSET_ASYNC;
        need_reg[g] <= 1'b1;
      end else if (rec_wr && peer_reg == ID_W'(g)) begin
        rec_per_reg[g] <= rec_per;
        rec_off_reg[g] <= rec_off;
        need_reg[g] <= rec_need;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t_data_reg <= '0;
      t_par_reg <= 1'b1;
      t_valid_reg <= 1'b0;
      phase_reg <= PH_OTHER;
      cur_period <= '0;
      cur_offset <= OFFSET_ASYNC;
      pace_cycles <= '0;
      sync_en <= 1'b0;
      ecs_active <= 1'b0;
      bus_free_pulse <= 1'b0;
    end else begin
      t_data_reg <= t_data_next;
      t_par_reg <= par_of(t_data_next) ^ corrupt;
      t_valid_reg <= t_valid_next;
      phase_reg <= phase_of(state_next);
      cur_period <= rec_per_reg[peer_reg];
      cur_offset <= rec_off_reg[peer_reg];
      pace_cycles <= pace_of(rec_per_reg[peer_reg]);
      sync_en <= data_phase && rec_off_reg[peer_reg] != OFFSET_ASYNC;
      ecs_active <= ecs_next;
      bus_free_pulse <= free_next;
    end
  end

  assign link.t_data = t_data_reg;
  assign link.t_par = t_par_reg;
  assign link.t_valid = t_valid_reg;
  assign link.phase = phase_reg;
endmodule : sdtr_target
`default_nettype wire

// ==== sdtr_pkg.sv ====
package sdtr_pkg;
  localparam logic [7:0] MSG_EXT = 8'h01;
  localparam logic [7:0] SDTR_EXT_LEN = 8'h03;
  localparam logic [7:0] SDTR_CODE = 8'h01;
  localparam logic [7:0] MSG_SAVE_DP = 8'h02;
  localparam logic [7:0] MSG_RESTORE = 8'h03;
  localparam logic [7:0] MSG_REJECT = 8'h07;
  localparam logic [7:0] MSG_PAR_ERR = 8'h09;
  localparam logic [7:0] MSG_DEV_RESET = 8'h0C;
  localparam logic [7:0] MSG_REL_RECOV = 8'h10;
  localparam logic [7:0] OFFSET_ASYNC = 8'h00;
  localparam logic [7:0] OFFSET_UNLIMITED = 8'hFF;
  localparam logic [2:0] SDTR_BYTES = 3'h5;
  localparam logic [2:0] ONE_BYTE = 3'h1;
  localparam logic [2:0] RX_LAST = 3'h4;
  localparam logic [15:0] PERIOD_UNIT_NS = 16'h0004;
  localparam logic [15:0] CLK_PERIOD_NS = 16'h0064;

  typedef logic [1:0] phase_t;
  localparam phase_t PH_BUS_FREE = 2'h0;
  localparam phase_t PH_OTHER = 2'h1;
  localparam phase_t PH_MSG_OUT = 2'h2;
  localparam phase_t PH_MSG_IN = 2'h3;

  // Odd parity over the byte.
  function automatic logic par_of(input logic [7:0] b);
    return ~^b;
  endfunction : par_of

  function automatic logic [39:0] sdtr_msg(input logic [7:0] per, input logic [7:0] off);
    return {MSG_EXT, SDTR_EXT_LEN, SDTR_CODE, per, off};
  endfunction : sdtr_msg

  // Clock cycles between REQ leading edges, rounded up.
  function automatic logic [7:0] pace_of(input logic [7:0] factor);
    logic [15:0] ns;
    ns = 16'(factor) * PERIOD_UNIT_NS;
    return 8'((ns + CLK_PERIOD_NS - 16'h0001) / CLK_PERIOD_NS);
  endfunction : pace_of
endpackage : sdtr_pkg

// ==== sdtr_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sdtr_link_if;
  logic [7:0] t_data;
  logic t_par;
  logic t_valid;
  logic [1:0] phase;
  logic [7:0] i_data;
  logic i_par;
  logic i_valid;
  logic atn;

  modport target_end(output t_data, output t_par, output t_valid, output phase,
    input i_data, input i_par, input i_valid, input atn);
  modport initiator_end(input t_data, input t_par, input t_valid, input phase,
    output i_data, output i_par, output i_valid, output atn);
endinterface : sdtr_link_if
`default_nettype wire

// ==== sdtr_initiator.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdtr_initiator #(
  parameter int PTR_W = 16
) (
  // Link to the target.
  sdtr_link_if.initiator_end link,
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Requests.
  input wire logic start_neg,
  input wire logic send_dev_reset,
  input wire logic send_rel_recov,
  input wire logic corrupt,
  input wire logic [7:0] min_period,
  input wire logic [7:0] max_offset,
  input wire logic data_step_en,
  input wire logic [PTR_W-1:0] data_step,
  // Agreement and pointers.
  output logic [7:0] agreed_period,
  output logic [7:0] agreed_offset,
  output logic [PTR_W-1:0] data_ptr,
  output logic [PTR_W-1:0] saved_ptr,
  output logic rewind_pulse
);
  import sdtr_pkg::*;

  logic atn_reg, atn_next;
  logic [39:0] msg_reg, msg_next;
  logic [2:0] len_reg, len_next;
  logic [2:0] idx_reg, idx_next;
  logic [7:0] i_data_reg, i_data_next;
  logic i_par_reg;
  logic i_valid_reg, i_valid_next;
  logic [2:0] rx_idx_reg, rx_idx_next;
  logic [23:0] rx_buf_reg, rx_buf_next;
  logic await_reg, await_next;
  logic answered_reg, answered_next;
  logic first_in_reg, first_in_next;
  logic [7:0] pend_per_reg, pend_per_next;
  logic [7:0] pend_off_reg, pend_off_next;
  logic [7:0] per_next, off_next;
  logic saved_ok_reg, saved_ok_next;
  logic [PTR_W-1:0] ptr_next, saved_next;
  logic rewind_next;
  phase_t prev_reg;

  wire phase_t ph = link.phase;
  // Bytes are dropped while our own message waits under attention, so the rest of a
  // message that had a parity error is never parsed as the start of a new one.
  wire rx_take = link.t_valid && ph == PH_MSG_IN && !atn_reg;
  wire par_good = link.t_par == par_of(link.t_data);
  wire idle_q = len_reg == 3'h0;
  wire [7:0] rx_per = rx_buf_reg[7:0];
  wire is_sdtr = rx_buf_reg[23:16] == SDTR_EXT_LEN && rx_buf_reg[15:8] == SDTR_CODE;
  wire [7:0] fit_per = (rx_per < min_period) ? min_period : rx_per;
  wire [7:0] fit_off = (link.t_data > max_offset) ? max_offset : link.t_data;
  wire reply_bad = rx_per < min_period || link.t_data > max_offset;
  wire left_mout = prev_reg == PH_MSG_OUT && ph != PH_MSG_OUT;
  wire aborted = ph != prev_reg && (ph == PH_BUS_FREE || (ph == PH_OTHER && prev_reg == PH_MSG_IN));
  wire last_out = ph == PH_MSG_OUT && !idle_q && idx_reg == len_reg - 3'h1;

  always_comb begin
    atn_next = atn_reg;
    msg_next = msg_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    i_data_next = i_data_reg;
    i_valid_next = 1'b0;
    rx_idx_next = rx_idx_reg;
    rx_buf_next = rx_buf_reg;
    await_next = await_reg;
    answered_next = answered_reg;
    first_in_next = first_in_reg;
    pend_per_next = pend_per_reg;
    pend_off_next = pend_off_reg;
    per_next = agreed_period;
    off_next = agreed_offset;
    saved_ok_next = saved_ok_reg;
    saved_next = saved_ptr;
    ptr_next = data_step_en ? data_ptr + data_step : data_ptr;
    rewind_next = 1'b0;
    if (idle_q && start_neg) begin
      msg_next = sdtr_msg(min_period, max_offset);
      len_next = SDTR_BYTES;
      idx_next = '0;
      atn_next = 1'b1;
      await_next = 1'b1;
    end else if (idle_q && (send_dev_reset || send_rel_recov)) begin
      msg_next = {send_dev_reset ? MSG_DEV_RESET : MSG_REL_RECOV, 32'h0};
      len_next = ONE_BYTE;
      idx_next = '0;
      atn_next = 1'b1;
    end
    if (ph == PH_MSG_OUT && !idle_q) begin
      i_valid_next = 1'b1;
      i_data_next = msg_reg[39 - 8 * idx_reg -: 8];
      idx_next = idx_reg + 3'h1;
      if (last_out) begin
        len_next = '0;
        atn_next = 1'b0;
        if (msg_reg[39:32] == MSG_DEV_RESET) begin
          per_next = 8'h00;
          off_next = OFFSET_ASYNC;
        end
      end
    end
    if (rx_take && !par_good) begin
      msg_next = {MSG_PAR_ERR, 32'h0};
      len_next = ONE_BYTE;
      idx_next = '0;
      atn_next = 1'b1;
      rx_idx_next = '0;
    end else if (rx_take && rx_idx_reg == 3'h0) begin
      first_in_next = 1'b0;
      case (link.t_data)
        MSG_SAVE_DP: begin
          saved_next = data_ptr;
          saved_ok_next = 1'b1;
        end
        MSG_RESTORE: begin
          ptr_next = saved_ok_reg ? saved_ptr : '0;
          rewind_next = 1'b1;
        end
        MSG_REJECT: begin
          if (await_reg || first_in_reg) begin
            per_next = 8'h00;
            off_next = OFFSET_ASYNC;
            await_next = 1'b0;
          end
        end
        MSG_EXT: begin
          rx_idx_next = 3'h1;
        end
        default: begin
        end
      endcase
    end else if (rx_take) begin
      rx_buf_next = {rx_buf_reg[15:0], link.t_data};
      rx_idx_next = rx_idx_reg + 3'h1;
      if (rx_idx_reg == RX_LAST && is_sdtr) begin
        rx_idx_next = '0;
        if (await_reg) begin
          await_next = 1'b0;
          per_next = reply_bad ? 8'h00 : rx_per;
          off_next = reply_bad ? OFFSET_ASYNC : link.t_data;
          if (reply_bad) begin
            msg_next = {MSG_REJECT, 32'h0};
            len_next = ONE_BYTE;
            idx_next = '0;
            atn_next = 1'b1;
          end
        end else begin
          msg_next = sdtr_msg(fit_per, fit_off);
          len_next = SDTR_BYTES;
          idx_next = '0;
          atn_next = 1'b1;
          answered_next = 1'b1;
          pend_per_next = fit_per;
          pend_off_next = fit_off;
        end
      end else if (rx_idx_reg == RX_LAST) begin
        rx_idx_next = '0;
      end
    end
    if (left_mout && answered_reg && idle_q) begin
      answered_next = 1'b0;
      first_in_next = ph != PH_BUS_FREE;
      per_next = (ph == PH_BUS_FREE) ? 8'h00 : pend_per_reg;
      off_next = (ph == PH_BUS_FREE) ? OFFSET_ASYNC : pend_off_reg;
    end
    if (await_reg && aborted) begin
      await_next = 1'b0;
      per_next = 8'h00;
      off_next = OFFSET_ASYNC;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      atn_reg <= 1'b0;
      msg_reg <= '0;
      len_reg <= '0;
      idx_reg <= '0;
      i_data_reg <= '0;
      i_par_reg <= 1'b1;
      i_valid_reg <= 1'b0;
      rx_idx_reg <= '0;
      rx_buf_reg <= '0;
      await_reg <= 1'b0;
      answered_reg <= 1'b0;
      first_in_reg <= 1'b0;
      pend_per_reg <= '0;
      pend_off_reg <= '0;
      agreed_period <= '0;
      agreed_offset <= OFFSET_ASYNC;
      saved_ok_reg <= 1'b0;
      data_ptr <= '0;
      saved_ptr <= '0;
      rewind_pulse <= 1'b0;
      prev_reg <= PH_OTHER;
    end else begin
      atn_reg <= atn_next;
      msg_reg <= msg_next;
      len_reg <= len_next;
      idx_reg <= idx_next;
      i_data_reg <= i_data_next;
      i_par_reg <= par_of(i_data_next) ^ corrupt;
      i_valid_reg <= i_valid_next;
      rx_idx_reg <= rx_idx_next;
      rx_buf_reg <= rx_buf_next;
      await_reg <= await_next;
      answered_reg <= answered_next;
      first_in_reg <= first_in_next;
      pend_per_reg <= pend_per_next;
      pend_off_reg <= pend_off_next;
      agreed_period <= per_next;
      agreed_offset <= off_next;
      saved_ok_reg <= saved_ok_next;
      data_ptr <= ptr_next;
      saved_ptr <= saved_next;
      rewind_pulse <= rewind_next;
      prev_reg <= ph;
    end
  end

  assign link.i_data = i_data_reg;
  assign link.i_par = i_par_reg;
  assign link.i_valid = i_valid_reg;
  assign link.atn = atn_reg;
endmodule : sdtr_initiator
`default_nettype wire

// ==== sdtr_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdtr_properties
  import sdtr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Link signals.
  input wire logic [7:0] t_data,
  input wire logic t_par,
  input wire logic t_valid,
  input wire logic [1:0] phase,
  input wire logic [7:0] i_data,
  input wire logic i_par,
  input wire logic i_valid,
  input wire logic atn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence t_head;
    t_valid && t_data == MSG_EXT ##1 t_valid && t_data == SDTR_EXT_LEN;
  endsequence
  sequence i_head;
    i_valid && i_data == MSG_EXT ##1 i_valid && i_data == SDTR_EXT_LEN;
  endsequence
  sequence i_whole;
    i_head ##1 i_valid && i_data == SDTR_CODE ##1 i_valid [*2];
  endsequence
  a_tx_sdtr_format: assert property (t_head |=> t_valid && t_data == SDTR_CODE ##1 t_valid [*2])
    else $error("target message bytes malformed");
  a_rx_sdtr_format: assert property (i_head |=> i_valid && i_data == SDTR_CODE ##1 i_valid [*2])
    else $error("initiator message bytes malformed");
  a_reply_follows: assert property (i_whole |-> ##[1:12] phase != PH_MSG_OUT)
    else $error("target stayed in message out");
  a_in_byte_phase: assert property (t_valid |-> phase == PH_MSG_IN)
    else $error("target byte outside message in");
  a_out_byte_phase: assert property (i_valid |-> phase == PH_MSG_OUT)
    else $error("initiator byte outside message out");
  a_out_needs_atn: assert property ($rose(phase == PH_MSG_OUT) |-> $past(atn))
    else $error("message out without attention");
  a_in_bytes_follow: assert property ($rose(phase == PH_MSG_IN) |-> ##[0:3] t_valid)
    else $error("message in without bytes");
  a_release_free: assert property (i_valid && i_data == MSG_REL_RECOV |-> ##[1:8] phase == PH_BUS_FREE)
    else $error("no bus free after release");
  a_dev_reset_free: assert property (i_valid && i_data == MSG_DEV_RESET |-> ##[1:8] phase == PH_BUS_FREE)
    else $error("no bus free after device reset");
endmodule : sdtr_properties
`default_nettype wire

// ==== sync_transfer_negotiation_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module sync_transfer_negotiation_test;
  import sdtr_pkg::*;
  typedef struct {logic [7:0] per; logic [7:0] off; logic ecs;} note_t;
  note_t notes[$];
  note_t n, m;
  logic clk = 1'b0, resetn = 1'b0, dp = 1'b1, t_bad = 1'b0;
  logic t_conn = 1'b0, t_start = 1'b0, i_start = 1'b0, i_rel = 1'b0, i_devrst = 1'b0, ecs_set = 1'b0;
  logic [7:0] t_min = 8'h20, t_max = 8'h04, i_min = 8'h20, i_max = 8'h04;
  logic [7:0] cur_p, cur_o, pace, i_per, i_off;
  logic sync_en, ecs, free_p;
  logic [3:0] peer = 4'h0;
  logic [1:0] prev_ph;
  int num_errors = 0, compares = 0, cycles = 0, frees = 0, seed, k, w;
  sdtr_link_if link();
  sdtr_target #(.MAX_RETRY(2)) sdtr_target_inst(.link(link), .clk(clk), .resetn(resetn),
    .peer_id(peer), .connect(t_conn), .start_neg(t_start), .ecs_set(ecs_set), .corrupt(t_bad),
    .data_phase(dp), .min_period(t_min), .max_offset(t_max), .cur_period(cur_p),
    .cur_offset(cur_o), .pace_cycles(pace), .sync_en(sync_en), .ecs_active(ecs),
    .bus_free_pulse(free_p));
  sdtr_initiator sdtr_initiator_inst(.link(link), .clk(clk), .resetn(resetn), .start_neg(i_start),
    .send_dev_reset(i_devrst), .send_rel_recov(i_rel), .corrupt(1'b0), .min_period(i_min),
    .max_offset(i_max), .data_step_en(1'b0), .data_step(16'h0000), .agreed_period(i_per),
    .agreed_offset(i_off), .data_ptr(), .saved_ptr(), .rewind_pulse());
  sdtr_properties sdtr_properties_inst(.clk(clk), .resetn(resetn), .t_data(link.t_data),
    .t_par(link.t_par), .t_valid(link.t_valid), .phase(link.phase), .i_data(link.i_data),
    .i_par(link.i_par), .i_valid(link.i_valid), .atn(link.atn));
  always #50 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // One pulse on a request line: 0 connect, 1 target start, 2 initiator start, 3..5 others.
  task automatic pulse(input int sel);
    {t_conn, t_start, i_start, i_rel, i_devrst, ecs_set} <= 6'h20 >> sel;
    @(posedge clk);
    {t_conn, t_start, i_start, i_rel, i_devrst, ecs_set} <= 6'h00;
  endtask : pulse
  task automatic settle();
    for (w = 0; w < 300 && notes.size() != 0; w++) @(posedge clk);
    repeat (5) @(posedge clk);
  endtask : settle
  always @(posedge clk) begin
    cycles++;
    if (free_p === 1'b1) frees++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // Each exchange ends when the link leaves the message phases.
  initial forever begin
    @(posedge clk);
    if (resetn && prev_ph[1] && !link.phase[1]) begin
      repeat (4) @(posedge clk);
      if (notes.size() == 0) chk("unexpected end", 8'h00, 8'h01);
      else begin
        m = notes.pop_front();
        chk("agreed_period", m.per, i_per);
        chk("agreed_offset", m.off, i_off);
        chk("cur_period", m.per, cur_p);
        chk("cur_offset", m.off, cur_o);
        chk("pace_cycles", 8'((m.per * 4 + 99) / 100), pace);
        chk("sync_en", {7'h00, m.off != 8'h00 && dp}, {7'h00, sync_en});
        chk("ecs_active", {7'h00, m.ecs}, {7'h00, ecs});
      end
    end
    prev_ph = link.phase;
  end
  initial begin
    seed = 32'hBDEB;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("agreed_offset", 8'h00, i_off);
    chk("cur_offset", 8'h00, cur_o);
    for (k = 0; k < 8; k++) begin
      t_min <= 8'h19 + 8'($random(seed) & 31);
      i_min <= 8'h19 + 8'($random(seed) & 31);
      t_max <= 8'h01 + 8'({$random(seed)} % 6);
      i_max <= 8'h01 + 8'({$random(seed)} % 6);
      dp <= 1'($random(seed));
      peer <= 4'(k & 1);
      @(posedge clk);
      n.per = (i_min > t_min) ? i_min : t_min;
      n.off = (i_max < t_max) ? i_max : t_max;
      n.ecs = 1'b0;
      if (k == 6) begin
        n.per = 8'h00;
        n.off = 8'h00;
      end
      notes.push_back(n);
      pulse(k < 2 ? k : 2);
      if (k == 3 || k == 6) begin
        for (w = 0; w < 50 && link.phase != PH_MSG_IN; w++) @(posedge clk);
        t_bad <= 1'b1;
        @(posedge clk);
        for (w = 0; w < 300 && k == 6 && link.phase[1]; w++) @(posedge clk);
        t_bad <= 1'b0;
      end
      settle();
    end
    for (k = 0; k < 2; k++) begin
      if (k == 0) begin
        pulse(5);
        @(posedge clk);
        chk("ecs_active", 8'h01, {7'h00, ecs});
      end
      notes.push_back(n);
      pulse(3);
      settle();
    end
    n.per = 8'h00;
    n.off = 8'h00;
    notes.push_back(n);
    pulse(4);
    settle();
    chk("notes left", 8'h00, 8'(notes.size()));
    chk("bus_free_pulses", 8'h04, 8'(frees));
    test_done();
  end
endmodule : sync_transfer_negotiation_test
`default_nettype wire
